// ---- src/ace_debounce.sv ----
// Debounce filter that resamples after a number of Timer 1 overflows
`timescale 1ns/1ps
`default_nettype none
module ace_debounce #(
  parameter int OVF_COUNT = ace_pkg::T1_OVF_COUNT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic active,
  input wire logic sample,
  input wire logic prev,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic t1_overflow,
  output logic hit
);
  import ace_pkg::*;

  localparam int CW = $clog2(OVF_COUNT + 1);

  if (OVF_COUNT < 1)
  begin : g_bad_count
    $error("OVF_COUNT must be at least 1");
  end

  ace_db_state_t state;
  ace_db_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic expect_level;
  logic next_expect_level;
  logic trig;
  logic last_ovf;

  assign trig = active & ((rise_en & sample & ~prev)
                        | (fall_en & ~sample & prev));
  assign last_ovf = t1_overflow && (cnt == CW'(OVF_COUNT - 1));

  assign hit = active && (state == DB_WAIT) && last_ovf
               && (sample == expect_level);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_expect_level = expect_level;
    unique case (state)
      DB_IDLE:
      begin
        if (trig)
        begin
          next_state = DB_WAIT;
          next_cnt = '0;
          next_expect_level = sample;
        end
      end
      DB_WAIT:
      begin
        if (last_ovf)
          next_state = DB_IDLE;
        else if (t1_overflow)
          next_cnt = cnt + CW'(1);
      end
    endcase
    if (!active)
      next_state = DB_IDLE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state <= DB_IDLE;
      cnt <= '0;
      expect_level <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      expect_level <= next_expect_level;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  hit_on_ovf_a: assert property (hit |-> t1_overflow && cnt == CW'(OVF_COUNT - 1))
    else $error("debounce hit outside final overflow");
  hit_expect_a: assert property (hit |-> sample == expect_level)
    else $error("debounce hit with wrong level");
  wait_hold_a: assert property (state == DB_WAIT && active
    && !t1_overflow |=> state == DB_WAIT)
    else $error("debounce left wait without overflow");
  trig_arm_a: assert property (state == DB_IDLE && trig |=> state == DB_WAIT && expect_level == $past(sample))
    else $error("debounce did not arm on transition");
  db_hit_c: cover property (state == DB_WAIT ##[1:200] hit);

endmodule // ace_debounce
`default_nettype wire

// ---- src/ace_pkg.sv ----
// Shared constants and types for the comparator event control block
package ace_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] CCS_ADDR = 8'h97;
  localparam logic [7:0] PORT3_ADDR = 8'hb0;

  // Field positions of comparator_control_status
  localparam int CM_LSB = 0;
  localparam int CM_W = 3;
  localparam int CEN_BIT = 3;
  localparam int CF_BIT = 4;
  localparam int RUN_IN_IDLE_BIT = 5;

  // Reset values
  localparam logic [7:0] CCS_RESET = 8'h00;
  localparam logic [7:0] PORT3_RESET = 8'hff;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Port 3 bit position that carries the comparator result
  localparam int P3_CMP_BIT = 6;

  // Timer 1 overflows awaited before a debounced resample
  localparam int T1_OVF_COUNT = 2;

  typedef enum logic [2:0] {
    MODE_LOW = 3'h0,
    MODE_RISE = 3'h1,
    MODE_DB_TOGGLE = 3'h2,
    MODE_DB_RISE = 3'h3,
    MODE_FALL = 3'h4,
    MODE_TOGGLE = 3'h5,
    MODE_DB_FALL = 3'h6,
    MODE_HIGH = 3'h7
  } ace_mode_t;

  typedef enum logic [0:0] {
    DB_IDLE = 1'b0,
    DB_WAIT = 1'b1
  } ace_db_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic rmw;
  } ace_sfr_req_t;

endpackage

// ---- src/ace_top.sv ----
// Comparator control, status register, event detection and port 3 view
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Result is one when positive input exceeds negative input, else zero.
// - Clearing comparator_on forces result low and blocks new flag events.
// - Port 3 pin reads return the live comparator result at bit 6.
// - Writes and read-modify-write of port 3 bit 6 touch only latch.
// - Flag sets on the selected condition while enabled; software clears.
// - Interrupt request only when compare_irq_enable is set.
// - Comparator result is sampled every clock for event detection.
// - Plain modes: 000 low, 001 rise, 100 fall, 101 toggle, 111 high.
// - Debounced modes: 010 toggle, 011 rise, 110 fall.
// - Debounced: wait two Timer 1 overflows, resample, match sets flag.
// - run_in_idle clear shuts comparator in Idle; set keeps it running.
// - Power-down always disables the comparator.
module ace_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire ace_pkg::ace_sfr_req_t sfr,
  output logic [7:0] sfr_rdata,
  input wire logic cmp_raw,
  input wire logic idle_mode,
  input wire logic powerdown_mode,
  input wire logic t1_overflow,
  input wire logic compare_irq_enable,
  input wire logic [7:0] port3_pins,
  output logic [7:0] port3_latch,
  output logic cmp_power_on,
  output logic cmp_result,
  output logic compare_irq
);
  import ace_pkg::*;

  logic cmp_s1;
  logic cmp_s2;
  logic [7:0] pins_s1;
  logic [7:0] pins_s2;
  logic prev_result;
  logic next_cmp_result;

  logic comparator_on;
  logic run_in_idle;
  logic compare_event_flag;
  ace_mode_t event_condition_select;
  logic next_on;
  logic next_run_idle;
  logic next_flag;
  ace_mode_t next_mode;
  logic [7:0] next_latch;
  logic [7:0] next_rdata;

  logic ccs_wr;
  logic p3_wr;
  logic active;
  logic plain_hit;
  logic db_rise_en;
  logic db_fall_en;
  logic db_hit;
  logic event_hit;
  logic [7:0] pin_view;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      pins_s1 <= 8'h00;
      pins_s2 <= 8'h00;
    end
    else
    begin
      cmp_s1 <= cmp_raw;
      cmp_s2 <= cmp_s1;
      pins_s1 <= port3_pins;
      pins_s2 <= pins_s1;
    end
  end

  assign ccs_wr = sfr.wr && (sfr.addr == CCS_ADDR);
  assign p3_wr = sfr.wr && (sfr.addr == PORT3_ADDR);

  assign active = comparator_on && !powerdown_mode
                  && (!idle_mode || run_in_idle);
  assign cmp_power_on = active;

  // sampled result forced low when off
  assign next_cmp_result = active & cmp_s2;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cmp_result <= 1'b0;
      prev_result <= 1'b0;
    end
    else
    begin
      cmp_result <= next_cmp_result;
      prev_result <= cmp_result;
    end
  end

  always_comb
  begin
    plain_hit = 1'b0;
    db_rise_en = 1'b0;
    db_fall_en = 1'b0;
    unique case (event_condition_select)
      MODE_LOW: plain_hit = !cmp_result;
      MODE_RISE: plain_hit = cmp_result && !prev_result;
      MODE_FALL: plain_hit = !cmp_result && prev_result;
      MODE_TOGGLE: plain_hit = cmp_result ^ prev_result;
      MODE_HIGH: plain_hit = cmp_result;
      MODE_DB_TOGGLE:
      begin
        db_rise_en = 1'b1;
        db_fall_en = 1'b1;
      end
      MODE_DB_RISE: db_rise_en = 1'b1;
      MODE_DB_FALL: db_fall_en = 1'b1;
    endcase
  end

  ace_debounce #(
    .OVF_COUNT(T1_OVF_COUNT)
  ) u_debounce (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .active(active),
    .sample(cmp_result),
    .prev(prev_result),
    .rise_en(db_rise_en),
    .fall_en(db_fall_en),
    .t1_overflow(t1_overflow),
    .hit(db_hit)
  );

  assign event_hit = active && (plain_hit || db_hit);

  // pin view carries the live result
  always_comb
  begin
    pin_view = pins_s2;
    pin_view[P3_CMP_BIT] = cmp_result;
  end

  always_comb
  begin
    next_on = comparator_on;
    next_run_idle = run_in_idle;
    next_flag = compare_event_flag;
    next_mode = event_condition_select;
    next_latch = port3_latch;
    next_rdata = sfr_rdata;
    // a register write loads the flag from the written CF bit
    if (ccs_wr)
    begin
      next_on = sfr.wdata[CEN_BIT];
      next_run_idle = sfr.wdata[RUN_IN_IDLE_BIT];
      next_flag = sfr.wdata[CF_BIT];
      next_mode = ace_mode_t'(sfr.wdata[CM_LSB +: CM_W]);
    end
    // a set in the clearing cycle wins
    if (event_hit)
      next_flag = 1'b1;
    // port writes reach only the latch
    if (p3_wr)
      next_latch = sfr.wdata;
    if (sfr.rd)
    begin
      next_rdata = RDATA_RESET;
      if (sfr.addr == CCS_ADDR)
      begin
        next_rdata[RUN_IN_IDLE_BIT] = run_in_idle;
        next_rdata[CF_BIT] = compare_event_flag;
        next_rdata[CEN_BIT] = comparator_on;
        next_rdata[CM_LSB +: CM_W] = event_condition_select;
      end
      else if (sfr.addr == PORT3_ADDR)
        // pins for reads, latch for read-modify-write
        next_rdata = sfr.rmw ? port3_latch : pin_view;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      comparator_on <= CCS_RESET[CEN_BIT];
      run_in_idle <= CCS_RESET[RUN_IN_IDLE_BIT];
      compare_event_flag <= CCS_RESET[CF_BIT];
      event_condition_select <= ace_mode_t'(CCS_RESET[CM_LSB +: CM_W]);
      port3_latch <= PORT3_RESET;
      sfr_rdata <= RDATA_RESET;
    end
    else
    begin
      comparator_on <= next_on;
      run_in_idle <= next_run_idle;
      compare_event_flag <= next_flag;
      event_condition_select <= next_mode;
      port3_latch <= next_latch;
      sfr_rdata <= next_rdata;
    end
  end

  assign compare_irq = compare_event_flag && compare_irq_enable;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  flag_set_a: assert property (event_hit |=> compare_event_flag)
    else $error("event did not set flag");
  flag_hold_a: assert property (compare_event_flag && !ccs_wr |=> compare_event_flag)
    else $error("flag cleared without software write");
  off_blocks_a: assert property (!comparator_on && !ccs_wr |=> !compare_event_flag || $past(compare_event_flag))
    else $error("flag set while comparator off");
  off_low_a: assert property (!comparator_on |=> !cmp_result)
    else $error("result not forced low when off");
  pd_off_a: assert property (powerdown_mode |-> !cmp_power_on ##1 !cmp_result)
    else $error("comparator active in power-down");
  idle_gate_a: assert property (idle_mode && !powerdown_mode && comparator_on |-> cmp_power_on == run_in_idle)
    else $error("idle gating wrong");
  irq_gate_a: assert property (compare_event_flag && !compare_irq_enable |-> !compare_irq)
    else $error("interrupt raised while disabled");
  high_level_a: assert property (active && event_condition_select == MODE_HIGH && cmp_result [*2] |=> compare_event_flag)
    else $error("high level did not set flag");
  rise_edge_a: assert property (active && event_condition_select == MODE_RISE && !prev_result && cmp_result |=> compare_event_flag)
    else $error("rising edge missed");
  pin_read_a: assert property (sfr.rd && !sfr.rmw && sfr.addr == PORT3_ADDR |=> sfr_rdata[P3_CMP_BIT] == $past(cmp_result))
    else $error("pin read lacks comparator result");
  latch_wr_a: assert property (p3_wr |=>
    port3_latch == $past(sfr.wdata) && comparator_on == $past(comparator_on))
    else $error("port write misbehaved");

  level_c: cover property (event_condition_select == MODE_LOW && event_hit);
  clear_c: cover property (compare_event_flag ##1 !compare_event_flag);
  pin_c: cover property (sfr.rd && sfr.addr == PORT3_ADDR && cmp_result);
  irq_c: cover property (compare_irq && idle_mode);

endmodule // ace_top
`default_nettype wire

// ---- testbench/ace_analog_model.sv ----
// Model of the analog comparator core and the Timer 1 overflow source
`timescale 1ns/1ps
`default_nettype none
module ace_analog_model #(
  parameter int T1_PERIOD = 20
) (
  input wire logic ref_clk,
  input wire logic t1_run,
  input wire logic [7:0] pos_level,
  input wire logic [7:0] neg_level,
  output logic cmp_raw,
  output logic t1_overflow
);
  int cnt = 0;
  logic ovf_q = 1'b0;
  assign cmp_raw = (pos_level > neg_level);
  // Stopping the timer restarts its period, so overflows are predictable
  always @(posedge ref_clk)
  begin
    cnt <= t1_run ? (cnt + 1) % T1_PERIOD : 0;
    ovf_q <= t1_run && (cnt == T1_PERIOD - 1);
  end
  assign t1_overflow = ovf_q;
endmodule // ace_analog_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking testbench for the comparator event control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ace_pkg::*;
  localparam int P = 20;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  ace_sfr_req_t sfr;
  logic idle_mode = 1'b0;
  logic powerdown_mode = 1'b0;
  logic compare_irq_enable = 1'b0;
  logic [7:0] port3_pins = 8'h0f;
  logic t1_run = 1'b0;
  logic [7:0] pos_level = 8'h10;
  logic [7:0] neg_level = 8'h20;
  logic [7:0] sfr_rdata;
  logic [7:0] port3_latch;
  logic cmp_raw;
  logic t1_overflow;
  logic cmp_power_on;
  logic cmp_result;
  logic compare_irq;
  logic [5:0] t;
  logic db;
  int n_fail = 0;
  int check_count = 0;
  // Glitch, expected flag, start level, mode
  logic [5:0] tab [14] = '{6'h11, 6'h09, 6'h1c, 6'h04, 6'h15, 6'h1d,
    6'h18, 6'h17, 6'h13, 6'h1e, 6'h12, 6'h1a, 6'h23, 6'h2e};

  ace_top dut (.ref_clk(ref_clk), .rstn(rstn), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .cmp_raw(cmp_raw), .idle_mode(idle_mode),
    .powerdown_mode(powerdown_mode), .t1_overflow(t1_overflow),
    .compare_irq_enable(compare_irq_enable), .port3_pins(port3_pins),
    .port3_latch(port3_latch), .cmp_power_on(cmp_power_on),
    .cmp_result(cmp_result), .compare_irq(compare_irq));

  ace_analog_model #(.T1_PERIOD(P)) phy (.ref_clk(ref_clk),
    .t1_run(t1_run), .pos_level(pos_level), .neg_level(neg_level),
    .cmp_raw(cmp_raw), .t1_overflow(t1_overflow));

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Waiting releases the bus, so strobes drop only where time passes
  task automatic cyc(input int n);
    sfr = '0;
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request stays up until the next call or wait replaces it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, rmw: 1'b0};
    @(negedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
    input logic m);
    sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, rmw: m};
    @(negedge ref_clk);
    compare(sfr_rdata, exp);
  endtask

  task automatic set_cmp(input logic v);
    pos_level = v ? 8'h30 : 8'h10;
  endtask

  initial
  begin
    #5ms;
    n_fail++;
    end_of_test;
  end

  initial
  begin
    cyc(2);
    rstn = 1'b1;
    cyc(2);
    rd(CCS_ADDR, 8'h00, 1'b0);
    rd(PORT3_ADDR, 8'hff, 1'b1);
    compare({7'h0, cmp_power_on}, 8'h00);
    wr(CCS_ADDR, 8'hc0);
    rd(CCS_ADDR, 8'h00, 1'b0);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00, 1'b0);
    rd(CCS_ADDR, 8'h00, 1'b0);
    foreach (tab[i])
    begin
      t = tab[i];
      db = t[1] & ~&t[2:0];
      wr(CCS_ADDR, 8'h00);
      set_cmp(t[3]);
      t1_run = 1'b1;
      wr(CCS_ADDR, {5'h01, t[2:0]});
      cyc(100);
      t1_run = 1'b0;
      wr(CCS_ADDR, {5'h01, t[2:0]});
      cyc(4);
      rd(CCS_ADDR, {5'h01, t[2:0]}, 1'b0);
      set_cmp(!t[3]);
      t1_run = 1'b1;
      cyc(8);
      rd(CCS_ADDR, {3'h0, t[4] & !db, 1'b1, t[2:0]}, 1'b0);
      if (t[5])
        set_cmp(t[3]);
      cyc(2 * P + 4);
      rd(CCS_ADDR, {3'h0, t[4], 1'b1, t[2:0]}, 1'b0);
      t1_run = 1'b0;
    end
    set_cmp(1'b1);
    wr(CCS_ADDR, 8'h0f);
    cyc(6);
    compare({7'h0, compare_irq}, 8'h00);
    compare_irq_enable = 1'b1;
    cyc(1);
    compare({7'h0, compare_irq}, 8'h01);
    rd(PORT3_ADDR, 8'h4f, 1'b0);
    wr(PORT3_ADDR, 8'h00);
    rd(PORT3_ADDR, 8'h00, 1'b1);
    compare({7'h0, cmp_result}, 8'h01);
    wr(PORT3_ADDR, 8'h40);
    rd(PORT3_ADDR, 8'h40, 1'b1);
    rd(CCS_ADDR, 8'h1f, 1'b0);
    compare(port3_latch, 8'h40);
    pos_level = 8'h20;
    cyc(5);
    compare({7'h0, cmp_result}, 8'h00);
    set_cmp(1'b1);
    idle_mode = 1'b1;
    cyc(1);
    compare({7'h0, cmp_power_on}, 8'h00);
    wr(CCS_ADDR, 8'h0f);
    cyc(6);
    rd(CCS_ADDR, 8'h0f, 1'b0);
    wr(CCS_ADDR, 8'h2f);
    cyc(6);
    compare({7'h0, cmp_power_on}, 8'h01);
    rd(CCS_ADDR, 8'h3f, 1'b0);
    compare({7'h0, compare_irq}, 8'h01);
    powerdown_mode = 1'b1;
    cyc(1);
    compare({7'h0, cmp_power_on}, 8'h00);
    wr(CCS_ADDR, 8'h2f);
    cyc(6);
    rd(CCS_ADDR, 8'h2f, 1'b0);
    idle_mode = 1'b0;
    powerdown_mode = 1'b0;
    wr(CCS_ADDR, 8'h07);
    wr(CCS_ADDR, 8'h07);
    cyc(6);
    compare({6'h0, cmp_result, cmp_power_on}, 8'h00);
    rd(CCS_ADDR, 8'h07, 1'b0);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
